// file: spi_ctl_pkg.sv
// shared constants of the spi control and status block
package spi_ctl_pkg;
   localparam logic [7:0] CTRL_ADDR = 8'hf8;
   localparam logic [7:0] CFG_ADDR = 8'ha1;
   localparam logic [7:0] DATA_ADDR = 8'ha3;
   localparam logic [7:0] CTRL_RESET = 8'h06;
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam int DONE_BIT = 7;
   localparam int WRITE_COLLISION_FLAG_BIT = 6;
   localparam int MODE_FAULT_FLAG_BIT = 5;
   localparam int OVR_BIT = 4;
   localparam int MODE_HI_BIT = 3;
   localparam int MODE_LO_BIT = 2;
   localparam int TXE_BIT = 1;
   localparam int EN_BIT = 0;
   localparam int MST_BIT = 6;
   localparam logic [1:0] MODE_THREE_WIRE = 2'h0;
   localparam logic [1:0] MODE_FOUR_WIRE_IN = 2'h1;
   localparam int BYTE_BITS = 8;
   localparam int CLK_HALF_CYCLES = 2;
endpackage : spi_ctl_pkg

// file: spi_sync2.sv
// two flip-flop level synchroniser into the system clock domain
`timescale 1ns/1ps
module spi_sync2 #(
   parameter int W = 1
) (
   input wire logic CLOCK,
   input wire logic SYS_RST,
   input wire logic [W-1:0] D,
   output logic [W-1:0] Q
);
   logic [W-1:0] meta_q;

   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         meta_q <= '0;
         Q <= '0;
      end else begin
         meta_q <= D;
         Q <= meta_q;
      end
   end
endmodule : spi_sync2

// file: spi_link_slave.sv
// slave shifter running on the serial clock from the far master
`timescale 1ns/1ps
module spi_link_slave (
   input wire logic SCK,
   input wire logic SYS_RST,
   input wire logic CLR,
   input wire logic MOSI,
   output logic MISO,
   input wire logic LOAD_TGL,
   input wire logic [7:0] TX_HOLD,
   output logic TAKEN_TGL,
   output logic DONE_TGL,
   output logic [7:0] RX_BYTE
);
   logic [2:0] cnt_q;
   logic [7:0] tx_sh_q;
   logic [6:0] rx_sh_q;
   logic load_m_q;
   logic load_s_q;
   logic pending;

   // clock may stop between frames, so the request toggle is resampled on every edge
   always_ff @(posedge SCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         load_m_q <= 1'b0;
         load_s_q <= 1'b0;
      end else begin
         load_m_q <= LOAD_TGL;
         load_s_q <= load_m_q;
      end
   end

   assign pending = load_s_q != TAKEN_TGL;

   // bit counter restarts whenever the port is deselected or disabled
   always_ff @(posedge SCK or posedge CLR) begin
      if (CLR) begin
         cnt_q <= 3'h0;
      end else begin
         cnt_q <= cnt_q + 3'h1;
      end
   end

   always_ff @(posedge SCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         tx_sh_q <= 8'h00;
         TAKEN_TGL <= 1'b0;
      end else if (cnt_q == 3'h0 && pending) begin
         tx_sh_q <= {TX_HOLD[6:0], 1'b0};
         TAKEN_TGL <= ~TAKEN_TGL;
      end else begin
         tx_sh_q <= {tx_sh_q[6:0], 1'b0};
      end
   end

   // at a byte boundary the next byte's top bit is shown before the first edge
   assign MISO = (cnt_q == 3'h0) ? (pending & TX_HOLD[7]) : tx_sh_q[7];

   always_ff @(posedge SCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         rx_sh_q <= 7'h00;
         RX_BYTE <= 8'h00;
         DONE_TGL <= 1'b0;
      end else begin
         rx_sh_q <= {rx_sh_q[5:0], MOSI};
         if (cnt_q == 3'(spi_ctl_pkg::BYTE_BITS - 1)) begin
            RX_BYTE <= {rx_sh_q, MOSI};
            DONE_TGL <= ~DONE_TGL;
         end
      end
   end
endmodule : spi_link_slave

// file: spi_control_status_flags.sv
// spi port control and status register, flags, fault detection and shifters
// What this block does
// - done flag with enable raises port interrupt
// - data write while transmit buffer full sets collision flag
// - select low, master, mode 01 sets fault
// - mode fault also raises port interrupt
// - fault flag cleared only by software
// - fault clears master and port enables
// - done flag set after every byte
// - colliding data write leaves buffer unchanged
// - select mode: 00 three-wire, 01 input, 1x output
`timescale 1ns/1ps
module spi_control_status_flags #(
   parameter int HALF_CYCLES = spi_ctl_pkg::CLK_HALF_CYCLES
) (
   input wire logic CLOCK,
   input wire logic SYS_RST,
   input wire logic [7:0] SFR_ADDR,
   input wire logic [7:0] SFR_WDATA,
   input wire logic SFR_WR,
   input wire logic SFR_RD,
   output logic [7:0] SFR_RDATA,
   input wire logic PORT_IRQ_ENABLE,
   output logic IRQ_REQ,
   input wire logic SCK_IN,
   output logic SCK_OUT,
   output logic SCK_OE,
   input wire logic MOSI_IN,
   output logic MOSI_OUT,
   output logic MOSI_OE,
   input wire logic MISO_IN,
   output logic MISO_OUT,
   output logic MISO_OE,
   input wire logic SLAVE_SELECT_IN,
   output logic SLAVE_SELECT_OUT,
   output logic SLAVE_SELECT_OE
);
   typedef enum logic {M_IDLE, M_RUN} master_state_t;

   logic transfer_done_flag_q;
   logic write_collision_flag_q;
   logic mode_fault_flag_q;
   logic receive_overrun_flag_q;
   logic [1:0] select_line_mode_q;
   logic port_enable_q;
   logic master_enable_q;
   logic tx_full_q;
   logic [7:0] tx_hold_q;
   logic load_tgl_q;
   logic [7:0] rx_buf_q;
   logic rx_unread_q;
   master_state_t m_state_q;
   logic [7:0] m_sh_q;
   logic [2:0] m_bits_q;
   logic [7:0] m_div_q;
   logic sck_q;
   logic slave_clr;
   logic wr_ctrl;
   logic wr_cfg;
   logic wr_data;
   logic rd_data;
   logic nss_low;
   logic miso_s;
   logic taken_s;
   logic taken_prev_q;
   logic done_s;
   logic done_prev_q;
   logic slave_taken_tgl;
   logic slave_done_tgl;
   logic [7:0] slave_rx_byte;
   logic slave_miso;
   logic mode_fault_set;
   logic collision_set;
   logic master_start;
   logic master_done;
   logic slave_done;
   logic byte_done;
   logic half_tick;
   logic [2:0] pin_s;

   function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] reg_addr);
      addr_hit = a == reg_addr;
   endfunction : addr_hit

   assign wr_ctrl = SFR_WR && addr_hit(SFR_ADDR, spi_ctl_pkg::CTRL_ADDR);
   assign wr_cfg = SFR_WR && addr_hit(SFR_ADDR, spi_ctl_pkg::CFG_ADDR);
   assign wr_data = SFR_WR && addr_hit(SFR_ADDR, spi_ctl_pkg::DATA_ADDR);
   assign rd_data = SFR_RD && addr_hit(SFR_ADDR, spi_ctl_pkg::DATA_ADDR);

   // select and miso pins and the slave take toggle pass two flops before CLOCK logic uses them
   spi_sync2 #(
      .W(3)
   ) u_pin_sync (
      .CLOCK(CLOCK),
      .SYS_RST(SYS_RST),
      .D({~SLAVE_SELECT_IN, MISO_IN, slave_taken_tgl}),
      .Q(pin_s)
   );

   spi_sync2 #(
      .W(1)
   ) u_done_sync (
      .CLOCK(CLOCK),
      .SYS_RST(SYS_RST),
      .D(slave_done_tgl),
      .Q(done_s)
   );

   assign nss_low = pin_s[2];
   assign miso_s = pin_s[1];
   assign taken_s = pin_s[0];

   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         taken_prev_q <= 1'b0;
         done_prev_q <= 1'b0;
      end else begin
         taken_prev_q <= taken_s;
         done_prev_q <= done_s;
      end
   end

   // slave bit counter is held clear while the port is off, a master, or deselected
   assign slave_clr = SYS_RST | ~port_enable_q | master_enable_q |
                      ((select_line_mode_q != spi_ctl_pkg::MODE_THREE_WIRE) &
                       SLAVE_SELECT_IN);

   spi_link_slave u_slave (
      .SCK(SCK_IN),
      .SYS_RST(SYS_RST),
      .CLR(slave_clr),
      .MOSI(MOSI_IN),
      .MISO(slave_miso),
      .LOAD_TGL(load_tgl_q),
      .TX_HOLD(tx_hold_q),
      .TAKEN_TGL(slave_taken_tgl),
      .DONE_TGL(slave_done_tgl),
      .RX_BYTE(slave_rx_byte)
   );

   assign slave_done = done_s != done_prev_q;
   assign byte_done = slave_done | master_done;

   // fault only matters while the select line is an input in multi-master use
   assign mode_fault_set = nss_low && master_enable_q &&
                           (select_line_mode_q == spi_ctl_pkg::MODE_FOUR_WIRE_IN);
   assign collision_set = wr_data && tx_full_q;

   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         transfer_done_flag_q <= spi_ctl_pkg::CTRL_RESET[spi_ctl_pkg::DONE_BIT];
         write_collision_flag_q <= spi_ctl_pkg::CTRL_RESET[spi_ctl_pkg::WRITE_COLLISION_FLAG_BIT];
         mode_fault_flag_q <= spi_ctl_pkg::CTRL_RESET[spi_ctl_pkg::MODE_FAULT_FLAG_BIT];
         receive_overrun_flag_q <= spi_ctl_pkg::CTRL_RESET[spi_ctl_pkg::OVR_BIT];
      end else begin
         // hardware set beats a clear written in the same cycle
         transfer_done_flag_q <= byte_done |
            (wr_ctrl ? SFR_WDATA[spi_ctl_pkg::DONE_BIT] : transfer_done_flag_q);
         write_collision_flag_q <= collision_set |
            (wr_ctrl ? SFR_WDATA[spi_ctl_pkg::WRITE_COLLISION_FLAG_BIT] : write_collision_flag_q);
         mode_fault_flag_q <= mode_fault_set |
            (wr_ctrl ? SFR_WDATA[spi_ctl_pkg::MODE_FAULT_FLAG_BIT] : mode_fault_flag_q);
         receive_overrun_flag_q <= (slave_done & rx_unread_q) |
            (wr_ctrl ? SFR_WDATA[spi_ctl_pkg::OVR_BIT] : receive_overrun_flag_q);
      end
   end

   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         select_line_mode_q <= spi_ctl_pkg::CTRL_RESET[spi_ctl_pkg::MODE_HI_BIT:
                                                       spi_ctl_pkg::MODE_LO_BIT];
         port_enable_q <= spi_ctl_pkg::CTRL_RESET[spi_ctl_pkg::EN_BIT];
         master_enable_q <= spi_ctl_pkg::CFG_RESET[spi_ctl_pkg::MST_BIT];
      end else begin
         if (wr_ctrl) begin
            select_line_mode_q <= SFR_WDATA[spi_ctl_pkg::MODE_HI_BIT:spi_ctl_pkg::MODE_LO_BIT];
         end
         // a fault releases the bus even against a software write
         if (mode_fault_set) begin
            port_enable_q <= 1'b0;
            master_enable_q <= 1'b0;
         end else begin
            if (wr_ctrl) begin
               port_enable_q <= SFR_WDATA[spi_ctl_pkg::EN_BIT];
            end
            if (wr_cfg) begin
               master_enable_q <= SFR_WDATA[spi_ctl_pkg::MST_BIT];
            end
         end
      end
   end

   // transmit buffer: a colliding write is dropped whole
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         tx_hold_q <= 8'h00;
         load_tgl_q <= 1'b0;
         tx_full_q <= 1'b0;
      end else begin
         if (wr_data && !tx_full_q) begin
            tx_hold_q <= SFR_WDATA;
            load_tgl_q <= ~load_tgl_q;
            tx_full_q <= 1'b1;
            // a master frame also clocks the idle slave shifter; its take must not empty the buffer
         end else if (master_start || ((taken_s != taken_prev_q) && !master_enable_q)) begin
            tx_full_q <= 1'b0;
         end
      end
   end

   // receive buffer: an unread byte is kept and a new slave byte lost; a master byte overwrites it
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         rx_buf_q <= 8'h00;
         rx_unread_q <= 1'b0;
      end else begin
         if (master_done) begin
            rx_buf_q <= {m_sh_q[6:0], miso_s};
            rx_unread_q <= 1'b1;
         end else if (slave_done && !rx_unread_q) begin
            rx_buf_q <= slave_rx_byte;
            rx_unread_q <= 1'b1;
         end else if (rd_data) begin
            rx_unread_q <= 1'b0;
         end
      end
   end

   // master engine: clock made here by dividing CLOCK, so it is no second domain
   assign half_tick = m_div_q == 8'(HALF_CYCLES - 1);
   assign master_start = (m_state_q == M_IDLE) && tx_full_q && port_enable_q &&
                         master_enable_q && !mode_fault_set;
   // miso is taken at the falling edge so the synchroniser delay stays inside the half period
   assign master_done = (m_state_q == M_RUN) && half_tick && sck_q &&
                        (m_bits_q == 3'(spi_ctl_pkg::BYTE_BITS - 1));

   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         m_state_q <= M_IDLE;
         m_sh_q <= 8'h00;
         m_bits_q <= 3'h0;
         m_div_q <= 8'h00;
         sck_q <= 1'b0;
      end else begin
         case (m_state_q)
            M_IDLE: begin
               m_div_q <= 8'h00;
               sck_q <= 1'b0;
               m_bits_q <= 3'h0;
               if (master_start) begin
                  m_sh_q <= tx_hold_q;
                  m_state_q <= M_RUN;
               end
            end
            M_RUN: begin
               if (!port_enable_q || !master_enable_q) begin
                  m_state_q <= M_IDLE;
               end else if (half_tick) begin
                  m_div_q <= 8'h00;
                  sck_q <= ~sck_q;
                  if (sck_q) begin
                     m_sh_q <= {m_sh_q[6:0], miso_s};
                     m_bits_q <= m_bits_q + 3'h1;
                     if (m_bits_q == 3'(spi_ctl_pkg::BYTE_BITS - 1)) begin
                        m_state_q <= M_IDLE;
                     end
                  end
               end else begin
                  m_div_q <= m_div_q + 8'h01;
               end
            end
            default: begin
               m_state_q <= M_IDLE;
            end
         endcase
      end
   end

   // pin drivers
   assign SCK_OUT = sck_q;
   assign SCK_OE = port_enable_q & master_enable_q;
   assign MOSI_OUT = m_sh_q[7];
   assign MOSI_OE = port_enable_q & master_enable_q;
   assign MISO_OUT = slave_miso;
   assign MISO_OE = port_enable_q & ~master_enable_q &
                    ((select_line_mode_q == spi_ctl_pkg::MODE_THREE_WIRE) | nss_low);
   assign SLAVE_SELECT_OUT = select_line_mode_q[0];
   assign SLAVE_SELECT_OE = select_line_mode_q[1];

   // interrupt request, leveled on the sticky flags
   assign IRQ_REQ = PORT_IRQ_ENABLE & (transfer_done_flag_q | write_collision_flag_q |
                    mode_fault_flag_q | receive_overrun_flag_q);

   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         SFR_RDATA <= 8'h00;
      end else if (SFR_RD) begin
         if (addr_hit(SFR_ADDR, spi_ctl_pkg::CTRL_ADDR)) begin
            SFR_RDATA <= {transfer_done_flag_q, write_collision_flag_q, mode_fault_flag_q,
                          receive_overrun_flag_q, select_line_mode_q, ~tx_full_q,
                          port_enable_q};
         end else if (addr_hit(SFR_ADDR, spi_ctl_pkg::CFG_ADDR)) begin
            SFR_RDATA <= {1'b0, master_enable_q, 6'h00};
         end else if (rd_data) begin
            SFR_RDATA <= rx_buf_q;
         end else begin
            SFR_RDATA <= 8'h00;
         end
      end
   end
endmodule : spi_control_status_flags

// file: spi_ctl_chk.sv
// assertions on the pins of the spi control and status port
`timescale 1ns/1ps
module spi_ctl_chk #(
   parameter int HALF_CYCLES = 2
) (
   input wire logic CLOCK,
   input wire logic SYS_RST,
   input wire logic [7:0] SFR_ADDR,
   input wire logic [7:0] SFR_WDATA,
   input wire logic SFR_WR,
   input wire logic PORT_IRQ_ENABLE,
   input wire logic IRQ_REQ,
   input wire logic SCK_OE,
   input wire logic MOSI_OE,
   input wire logic SLAVE_SELECT_IN,
   input wire logic SLAVE_SELECT_OUT,
   input wire logic SLAVE_SELECT_OE
);
   localparam int DONE_MAX = 16 * HALF_CYCLES + 8;
   logic ctl_wr, dat_wr, flt;
   logic [1:0] mode_w;
   assign ctl_wr = SFR_WR && SFR_ADDR == spi_ctl_pkg::CTRL_ADDR;
   assign dat_wr = SFR_WR && SFR_ADDR == spi_ctl_pkg::DATA_ADDR;
   assign mode_w = SFR_WDATA[3:2];
   // enabled master in mode 01 with select low; the sync adds two cycles
   assign flt = SCK_OE && !SLAVE_SELECT_OE && SLAVE_SELECT_OUT && !SLAVE_SELECT_IN;
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (SYS_RST);
   property p_irq_off; !PORT_IRQ_ENABLE |-> !IRQ_REQ; endproperty
   a_irq_off: assert property (p_irq_off) else $error("irq while disabled");
   property p_sel_mode;
      ctl_wr |=> {SLAVE_SELECT_OE, SLAVE_SELECT_OUT} == $past(mode_w);
   endproperty
   a_sel_mode: assert property (p_sel_mode) else $error("select pin mode wrong");
   property p_fault_off; flt [*3] |-> ##[1:4] !SCK_OE; endproperty
   a_fault_off: assert property (p_fault_off) else $error("fault left port on");
   property p_fault_irq; (flt && PORT_IRQ_ENABLE) [*3] |-> ##[1:4] IRQ_REQ; endproperty
   a_fault_irq: assert property (p_fault_irq) else $error("fault gave no irq");
   property p_flag_hold; IRQ_REQ && !ctl_wr |=> IRQ_REQ || !PORT_IRQ_ENABLE; endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("flag dropped alone");
   property p_write_collision_flag_irq;
      dat_wr && SCK_OE && PORT_IRQ_ENABLE ##1 dat_wr && PORT_IRQ_ENABLE |-> ##[1:2] IRQ_REQ;
   endproperty
   a_write_collision_flag_irq: assert property (p_write_collision_flag_irq) else $error("collision gave no irq");
   property p_done;
      dat_wr && SCK_OE && PORT_IRQ_ENABLE |-> ##[1:DONE_MAX] (IRQ_REQ || !SCK_OE);
   endproperty
   a_done: assert property (p_done) else $error("byte never done");
   property p_mode_guard; SCK_OE && SLAVE_SELECT_OE && !SFR_WR |=> SCK_OE; endproperty
   a_mode_guard: assert property (p_mode_guard) else $error("fault outside mode 01");
   property p_oe_pair; MOSI_OE == SCK_OE; endproperty
   a_oe_pair: assert property (p_oe_pair) else $error("master pins disagree");
   c_fault: cover property (flt [*3]);
   c_write_collision_flag: cover property (dat_wr ##1 dat_wr);
   c_irq: cover property ($rose(IRQ_REQ));
endmodule : spi_ctl_chk

bind spi_control_status_flags spi_ctl_chk #(.HALF_CYCLES(HALF_CYCLES)) i_chk (.CLOCK,
   .SYS_RST, .SFR_ADDR, .SFR_WDATA, .SFR_WR, .PORT_IRQ_ENABLE, .IRQ_REQ, .SCK_OE,
   .MOSI_OE, .SLAVE_SELECT_IN, .SLAVE_SELECT_OUT, .SLAVE_SELECT_OE);

// file: spi_far_dev.sv
// far spi party: slave to the port as master, master to the port as slave
`timescale 1ns/1ps
module spi_far_dev (
   input wire logic sck_m,
   input wire logic mosi_m,
   output logic miso_m,
   output logic sck_s,
   output logic mosi_s,
   input wire logic miso_s,
   output logic ss_n
);
   logic [7:0] tx_q = 8'h00;
   logic [7:0] rx_q = 8'h00;
   initial begin
      sck_s = 1'b0;
      mosi_s = 1'b1;
      ss_n = 1'b1;
   end
   assign miso_m = tx_q[7];
   always @(posedge sck_m) begin
      rx_q <= {rx_q[6:0], mosi_m};
   end
   // shift on the fall: the port samples late through its synchroniser
   always @(negedge sck_m) begin
      tx_q <= {tx_q[6:0], ~tx_q[0]};
   end
   // link clock runs only inside a frame
   task automatic xfer(input logic [7:0] b, output logic [7:0] r);
      #9;
      ss_n = 1'b0;
      #213;
      for (int i = 7; i >= 0; i--) begin
         mosi_s = b[i];
         #80;
         r = {r[6:0], miso_s};
         sck_s = 1'b1;
         #80;
         sck_s = 1'b0;
      end
      mosi_s = ~mosi_s;
      #200;
      ss_n = 1'b1;
   endtask : xfer
endmodule : spi_far_dev

// file: testbench.sv
// self-checking bench for the spi control and status port
`timescale 1ns/1ps
module testbench;
   localparam int HC = 2;
   logic clock, sys_rst, sfr_wr, sfr_rd, irq_en, irq;
   logic [7:0] addr, wdata, rdata, d, b, t, r;
   logic sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_o, ss_oe;
   logic sck_s, mosi_s, miso_m, ss_n, sck_w, mosi_w, miso_w, ss_w;
   int n_fail = 0;
   int cmp_count = 0;
   assign sck_w = sck_oe ? sck_o : sck_s;
   assign mosi_w = mosi_oe ? mosi_o : mosi_s;
   assign miso_w = miso_oe ? miso_o : miso_m;
   assign ss_w = ss_oe ? ss_o : ss_n;
   spi_control_status_flags #(.HALF_CYCLES(HC)) i_spi_control_status_flags (
      .CLOCK(clock), .SYS_RST(sys_rst), .SFR_ADDR(addr), .SFR_WDATA(wdata), .SFR_WR(sfr_wr),
      .SFR_RD(sfr_rd), .SFR_RDATA(rdata), .PORT_IRQ_ENABLE(irq_en), .IRQ_REQ(irq),
      .SCK_IN(sck_w), .SCK_OUT(sck_o), .SCK_OE(sck_oe), .MOSI_IN(mosi_w),
      .MOSI_OUT(mosi_o), .MOSI_OE(mosi_oe), .MISO_IN(miso_w), .MISO_OUT(miso_o),
      .MISO_OE(miso_oe), .SLAVE_SELECT_IN(ss_w), .SLAVE_SELECT_OUT(ss_o),
      .SLAVE_SELECT_OE(ss_oe));
   spi_far_dev i_spi_far_dev (.sck_m(sck_w), .mosi_m(mosi_w), .miso_m(miso_m),
      .sck_s(sck_s), .mosi_s(mosi_s), .miso_s(miso_w), .ss_n(ss_n));
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   function automatic logic [7:0] cs(logic [3:0] f, logic [1:0] m, logic e);
      return {f, m, 1'b1, e};
   endfunction : cs
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask : chk
   // two set back to back writes a second, inverted byte on the next edge
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] v, input logic two = 0);
      @(posedge clock);
      addr <= a;
      wdata <= v;
      sfr_wr <= 1'b1;
      if (two) begin
         @(posedge clock);
         wdata <= ~v;
      end
      @(posedge clock);
      sfr_wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a);
      @(posedge clock);
      addr <= a;
      sfr_rd <= 1'b1;
      @(posedge clock);
      sfr_rd <= 1'b0;
      @(negedge clock);
      d = rdata;
   endtask : rd_reg
   task automatic ck_reg(input logic [7:0] a, input logic [7:0] e);
      rd_reg(a);
      chk($sformatf("reg %h", a), e, d);
   endtask : ck_reg
   // polls the control register; running out of polls counts as a mismatch
   task automatic wait_done;
      for (int k = 0; k < 200; k++) begin
         rd_reg(spi_ctl_pkg::CTRL_ADDR);
         if (d[spi_ctl_pkg::DONE_BIT]) return;
      end
      n_fail++;
      $display("BAD done flag exp 1 got 0");
   endtask : wait_done
   task automatic results;
      if (n_fail == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : results
   initial begin
      #2000000;
      n_fail++;
      results();
   end
   initial begin
      sys_rst = 1'b1;
      addr = 8'h00;
      wdata = 8'h00;
      sfr_wr = 1'b0;
      sfr_rd = 1'b0;
      irq_en = 1'b0;
      void'($urandom(32'hedf9));
      repeat (12) @(posedge clock);
      sys_rst <= 1'b0;
      ck_reg(spi_ctl_pkg::CTRL_ADDR, spi_ctl_pkg::CTRL_RESET);
      ck_reg(spi_ctl_pkg::CFG_ADDR, spi_ctl_pkg::CFG_RESET);
      ck_reg(8'h55, 8'h00);
      for (int m = 0; m < 4; m++) begin
         wr_reg(spi_ctl_pkg::CTRL_ADDR, {4'h0, m[1:0], 2'b00});
         @(negedge clock);
         chk("sel", {6'h0, m[1:0]}, {6'h0, ss_oe, ss_o});
         ck_reg(spi_ctl_pkg::CTRL_ADDR, cs(4'h0, m[1:0], 1'b0));
      end
      irq_en <= 1'b1;
      wr_reg(spi_ctl_pkg::CTRL_ADDR, 8'hec);
      repeat (20) @(posedge clock);
      ck_reg(spi_ctl_pkg::CTRL_ADDR, cs(4'he, 2'b11, 1'b0));
      wr_reg(spi_ctl_pkg::CTRL_ADDR, 8'h0c);
      ck_reg(spi_ctl_pkg::CTRL_ADDR, cs(4'h0, 2'b11, 1'b0));
      chk("irq", 8'h00, {7'h0, irq});
      wr_reg(spi_ctl_pkg::CFG_ADDR, 8'h01 << spi_ctl_pkg::MST_BIT);
      for (int i = 0; i < 6; i++) begin
         b = $urandom;
         t = $urandom;
         irq_en <= i[0];
         wr_reg(spi_ctl_pkg::CTRL_ADDR, 8'h0d);
         i_spi_far_dev.tx_q = t;
         wr_reg(spi_ctl_pkg::DATA_ADDR, b, i == 5);
         wait_done();
         chk("far rx", b, i_spi_far_dev.rx_q);
         ck_reg(spi_ctl_pkg::DATA_ADDR, t);
         ck_reg(spi_ctl_pkg::CTRL_ADDR, cs({1'b1, i == 5, 2'b00}, 2'b11, 1'b1));
         chk("irq", {7'h0, i[0]}, {7'h0, irq});
      end
      irq_en <= 1'b1;
      @(posedge clock);
      i_spi_far_dev.ss_n <= 1'b0;
      repeat (10) @(posedge clock);
      ck_reg(spi_ctl_pkg::CTRL_ADDR, cs(4'hc, 2'b11, 1'b1));
      wr_reg(spi_ctl_pkg::CTRL_ADDR, 8'h05);
      repeat (10) @(posedge clock);
      ck_reg(spi_ctl_pkg::CTRL_ADDR, cs(4'h2, 2'b01, 1'b0));
      ck_reg(spi_ctl_pkg::CFG_ADDR, 8'h00);
      chk("irq", 8'h01, {7'h0, irq});
      i_spi_far_dev.ss_n <= 1'b1;
      repeat (10) @(posedge clock);
      ck_reg(spi_ctl_pkg::CTRL_ADDR, cs(4'h2, 2'b01, 1'b0));
      wr_reg(spi_ctl_pkg::CFG_ADDR, 8'h00);
      for (int i = 0; i < 4; i++) begin
         b = $urandom;
         wr_reg(spi_ctl_pkg::CTRL_ADDR, {5'h0, i[0], 2'b01});
         // slave load needs two link edges, so the byte goes out one frame later
         if (i == 0) wr_reg(spi_ctl_pkg::DATA_ADDR, t, 1'b1);
         i_spi_far_dev.xfer(b, r);
         wait_done();
         if (i == 1) chk("slave tx", t, r);
         // the byte of frame 2 is left unread so frame 3 overruns
         if (i == 2) t = b;
         else ck_reg(spi_ctl_pkg::DATA_ADDR, (i == 3) ? t : b);
         if (i == 0) ck_reg(spi_ctl_pkg::CTRL_ADDR, 8'hc1);
         else ck_reg(spi_ctl_pkg::CTRL_ADDR, cs({3'h4, i == 3}, {1'b0, i[0]}, 1'b1));
      end
      results();
   end
endmodule : testbench
